// ### pfl_pkg.sv
/*
  Shared constants and types for the loop feedback and lock detect block.
  Assumes an 8-bit register port and tick inputs synchronous to core_clk.
*/
package pfl_pkg;

  // Clock and static-clock timeout
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned STATIC_TIME_NS = 2000;
  localparam int unsigned STATIC_CYCLES = STATIC_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned STATIC_W = $clog2(STATIC_CYCLES + 1);

  // Register offsets
  localparam logic [7:0] ADDR_LOOP_CFG = 8'h20;
  localparam logic [7:0] ADDR_TH_LO = 8'h21;
  localparam logic [7:0] ADDR_TH_HI = 8'h22;
  localparam logic [7:0] ADDR_GOOD_CNT = 8'h23;
  localparam logic [7:0] ADDR_M0_LO = 8'h24;
  localparam logic [7:0] ADDR_M0_HI = 8'h25;
  localparam logic [7:0] ADDR_M1_LO = 8'h26;
  localparam logic [7:0] ADDR_M1_HI = 8'h27;
  localparam logic [7:0] ADDR_P1 = 8'h28;
  localparam logic [7:0] ADDR_GPIO_SEL = 8'h29;
  localparam logic [7:0] ADDR_SYNTH_DIV_HI = 8'h2C;
  localparam logic [7:0] ADDR_SYNTH_DIV_LO = 8'h2D;
  localparam logic [7:0] ADDR_STATUS = 8'h2E;

  // Loop configuration field positions
  localparam int unsigned CFG_ROUTE_BIT = 0;
  localparam int unsigned CFG_OSC_HALVE_BIT = 1;
  localparam int unsigned CFG_EXT_HALVE_BIT = 2;
  localparam int unsigned CFG_DOUBLER_BIT = 3;
  localparam int unsigned CFG_FORCE_BIT = 4;
  localparam int unsigned CFG_MODE_LSB = 5;

  // Status field positions
  localparam int unsigned ST_L1_LIVE_BIT = 0;
  localparam int unsigned ST_L2_LIVE_BIT = 1;
  localparam int unsigned ST_L1_LATCH_BIT = 2;
  localparam int unsigned ST_L2_LATCH_BIT = 3;

  // Reset values
  localparam logic [7:0] LOOP_CFG_RST = 8'h10;
  localparam logic [14:0] TH_RST = 15'h0010;
  localparam logic [1:0] GOOD_CNT_RST = 2'h1;
  localparam logic [14:0] M0_RST = 15'h0004;
  localparam logic [13:0] M1_RST = 14'h0001;
  localparam logic [6:0] P1_RST = 7'h01;
  localparam logic [3:0] GPIO_SEL_RST = 4'h4;
  localparam logic [7:0] SYNTH_DIV_HI_RST = 8'h00;
  localparam logic [7:0] SYNTH_DIV_LO_RST = 8'h10;

  // GPIO source codes
  localparam logic [1:0] GPIO_SRC_L1_LOCK = 2'h0;
  localparam logic [1:0] GPIO_SRC_L2_LOCK = 2'h1;
  localparam logic [1:0] GPIO_SRC_L1_LOSS = 2'h2;

  typedef enum logic [1:0] {
    MODE_DUAL = 2'b00,
    MODE_SYNTH = 2'b01,
    MODE_VCXO = 2'b10,
    MODE_BYPASS = 2'b11
  } pfl_mode_e;

  typedef struct packed {
    pfl_mode_e mode;
    logic center_force;
    logic doubler_en;
    logic ext_halve;
    logic osc_halve;
    logic route_sel;
  } pfl_cfg_s;

  typedef struct packed {
    logic l2_latched;
    logic l1_latched;
    logic l2_live;
    logic l1_live;
  } pfl_status_s;

endpackage : pfl_pkg

// ### pfl_tick_div.sv
/*
  Integer divider for one-cycle tick pulses.
  Assumes tick_in is synchronous to core_clk; a ratio of 0 acts as 1.
*/
`timescale 1ns/100ps
module pfl_tick_div
  import pfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick_in,
  input wire logic [15:0] ratio,
  output logic tick_out
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_reg;
  logic wrap;

  // Wrap when the last input tick of a period arrives
  assign wrap = tick_in && ((cnt_reg + 16'h0001) >= ratio);
  assign cnt_next = !tick_in ? cnt_reg : (wrap ? 16'h0000 : cnt_reg + 16'h0001);
  assign tick_out = tick_reg;

  // Count and emit one pulse per period
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= wrap;
    end
  end

endmodule : pfl_tick_div

// ### pfl_lock_ctrl.sv
/*
  Feedback routing, divider selection and lock detection for both loops.
  Assumes tick inputs are one-cycle pulses synchronous to core_clk.
*/
`timescale 1ns/100ps
module pfl_lock_ctrl
  import pfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic ref_in_tick,
  input wire logic ref_pd_tick,
  input wire logic vcxo_tick,
  input wire logic vco_tick,
  input wire logic [14:0] pd_phase_err,
  input wire logic holdover,
  input wire logic synth_cal_done,
  input wire logic synth_vtune_in_window,
  output logic first_loop_fb_tick,
  output logic synth_fb_tick,
  output logic synth_pfd_tick,
  output logic synth_doubler_on,
  output logic vco_eff_tick,
  output logic delay_ref_tick,
  output logic oscillator_center_force,
  output logic [1:0] gpio_out
);

  // Register storage
  pfl_cfg_s cfg_reg;
  logic [14:0] phase_window_threshold_reg;
  logic [1:0] good_count_reg;
  logic [14:0] first_loop_feedback_div_reg;
  logic [13:0] cascade_feedback_div_reg;
  logic [6:0] synth_ref_prediv_reg;
  logic [3:0] gpio_sel_reg;
  logic [7:0] synth_feedback_divider_hi_reg;
  logic [7:0] synth_feedback_divider_lo_reg;
  logic first_loop_lock_latched_reg;
  logic second_loop_lock_latched_reg;
  logic [7:0] reg_rdata_reg;

  // Address decode
  logic wr_cfg, wr_th_lo, wr_th_hi, wr_good, wr_m0_lo, wr_m0_hi;
  logic wr_m1_lo, wr_m1_hi, wr_p1, wr_gpio, wr_m2_hi, wr_m2_lo, wr_status;
  assign wr_cfg = reg_wr_en && (reg_addr == ADDR_LOOP_CFG);
  assign wr_th_lo = reg_wr_en && (reg_addr == ADDR_TH_LO);
  assign wr_th_hi = reg_wr_en && (reg_addr == ADDR_TH_HI);
  assign wr_good = reg_wr_en && (reg_addr == ADDR_GOOD_CNT);
  assign wr_m0_lo = reg_wr_en && (reg_addr == ADDR_M0_LO);
  assign wr_m0_hi = reg_wr_en && (reg_addr == ADDR_M0_HI);
  assign wr_m1_lo = reg_wr_en && (reg_addr == ADDR_M1_LO);
  assign wr_m1_hi = reg_wr_en && (reg_addr == ADDR_M1_HI);
  assign wr_p1 = reg_wr_en && (reg_addr == ADDR_P1);
  assign wr_gpio = reg_wr_en && (reg_addr == ADDR_GPIO_SEL);
  assign wr_m2_hi = reg_wr_en && (reg_addr == ADDR_SYNTH_DIV_HI);
  assign wr_m2_lo = reg_wr_en && (reg_addr == ADDR_SYNTH_DIV_LO);
  assign wr_status = reg_wr_en && (reg_addr == ADDR_STATUS);

  // Configuration registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= pfl_cfg_s'(LOOP_CFG_RST[6:0]);
      phase_window_threshold_reg <= TH_RST;
      good_count_reg <= GOOD_CNT_RST;
      first_loop_feedback_div_reg <= M0_RST;
      cascade_feedback_div_reg <= M1_RST;
      synth_ref_prediv_reg <= P1_RST;
      gpio_sel_reg <= GPIO_SEL_RST;
      synth_feedback_divider_hi_reg <= SYNTH_DIV_HI_RST;
      synth_feedback_divider_lo_reg <= SYNTH_DIV_LO_RST;
    end else begin
      if (wr_cfg) cfg_reg <= pfl_cfg_s'(reg_wdata[6:0]);
      if (wr_th_lo) phase_window_threshold_reg[7:0] <= reg_wdata;
      if (wr_th_hi) phase_window_threshold_reg[14:8] <= reg_wdata[6:0];
      if (wr_good) good_count_reg <= reg_wdata[1:0];
      if (wr_m0_lo) first_loop_feedback_div_reg[7:0] <= reg_wdata;
      if (wr_m0_hi) first_loop_feedback_div_reg[14:8] <= reg_wdata[6:0];
      if (wr_m1_lo) cascade_feedback_div_reg[7:0] <= reg_wdata;
      if (wr_m1_hi) cascade_feedback_div_reg[13:8] <= reg_wdata[5:0];
      if (wr_p1) synth_ref_prediv_reg <= reg_wdata[6:0];
      if (wr_gpio) gpio_sel_reg <= reg_wdata[3:0];
      if (wr_m2_hi) synth_feedback_divider_hi_reg <= reg_wdata;
      if (wr_m2_lo) synth_feedback_divider_lo_reg <= reg_wdata;
    end
  end

  assign oscillator_center_force = cfg_reg.center_force;

  // Oscillator halving, one tick in two passes; the VCO path halves only when ext_halve is set
  logic vco_half_tick, vcxo_half_tick;
  logic [15:0] ext_ratio, osc_ratio;
  assign ext_ratio = cfg_reg.ext_halve ? 16'h0002 : 16'h0001;
  assign osc_ratio = 16'h0002;

  pfl_tick_div u_vco_half (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(vco_tick),
    .ratio(ext_ratio),
    .tick_out(vco_half_tick)
  );

  pfl_tick_div u_vcxo_half (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(vcxo_tick),
    .ratio(osc_ratio),
    .tick_out(vcxo_half_tick)
  );

  // halved clock feeds synth divider and outputs
  assign vco_eff_tick = vco_half_tick;

  // Cascade divider on the second loop output
  logic m1_tick;
  pfl_tick_div u_cascade_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(vco_half_tick),
    .ratio({2'h0, cascade_feedback_div_reg}),
    .tick_out(m1_tick)
  );

  // First loop feedback route selection
  logic vcxo_path_tick, m0_in_tick, m0_tick;
  // optional halving on the independent route
  assign vcxo_path_tick = cfg_reg.osc_halve ? vcxo_half_tick : vcxo_tick;
  assign m0_in_tick = cfg_reg.route_sel ? m1_tick : vcxo_path_tick;

  pfl_tick_div u_first_fb_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(m0_in_tick),
    .ratio({1'b0, first_loop_feedback_div_reg}),
    .tick_out(m0_tick)
  );
  assign first_loop_fb_tick = m0_tick;

  pfl_tick_div u_synth_fb_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(vco_half_tick),
    .ratio({synth_feedback_divider_hi_reg, synth_feedback_divider_lo_reg}),
    .tick_out(synth_fb_tick)
  );

  // Synth input is first loop output, or the input clock in synth mode
  logic synth_in_tick;
  logic [15:0] p1_ratio;
  assign synth_in_tick = (cfg_reg.mode == MODE_SYNTH) ? ref_in_tick : vcxo_tick;
  assign p1_ratio = cfg_reg.doubler_en ? 16'h0001 : {9'h000, synth_ref_prediv_reg};
  assign synth_doubler_on = cfg_reg.doubler_en;

  pfl_tick_div u_synth_prediv (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick_in(synth_in_tick),
    .ratio(p1_ratio),
    .tick_out(synth_pfd_tick)
  );

  // Source selector output for the delay circuits
  logic src_tick;
  logic delay_ref_reg;
  // delay reference from selector; only the VCO source is after halving
  assign src_tick = (cfg_reg.mode == MODE_BYPASS) ? ref_in_tick :
                    (cfg_reg.mode == MODE_VCXO) ? vcxo_tick : vco_half_tick;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) delay_ref_reg <= 1'b0;
    else delay_ref_reg <= src_tick;
  end
  assign delay_ref_tick = delay_ref_reg;

  // Static-clock watchdogs: 0 first loop feedback, 1 first loop reference,
  // 2 second loop input. A silent clock never advances lock logic, so only
  // a timeout can show the loss.
  logic [2:0] wd_tick;
  logic [2:0] wd_alive;
  assign wd_tick = {synth_pfd_tick, ref_pd_tick, m0_tick};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_wd
      logic [STATIC_W-1:0] idle_reg;
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) idle_reg <= STATIC_W'(STATIC_CYCLES);
        else if (wd_tick[gi]) idle_reg <= '0;
        else if (idle_reg != STATIC_W'(STATIC_CYCLES)) idle_reg <= idle_reg + STATIC_W'(1);
      end
      assign wd_alive[gi] = (idle_reg != STATIC_W'(STATIC_CYCLES));
    end
  endgenerate

  // First loop lock qualification
  logic l1_mode_ok, l1_enable, l1_err_ok;
  logic [2:0] good_run_reg;
  logic [2:0] good_run_next;
  logic first_loop_lock_live;
  // only in dual and oscillator-only modes
  assign l1_mode_ok = (cfg_reg.mode == MODE_DUAL) || (cfg_reg.mode == MODE_VCXO);
  assign l1_enable = l1_mode_ok && wd_alive[0] && wd_alive[1] &&
                     !cfg_reg.center_force && !holdover;
  assign l1_err_ok = (pd_phase_err <= phase_window_threshold_reg);
  // run of in-window feedback cycles, saturating
  assign good_run_next = !l1_enable ? 3'h0 :
                         !m0_tick ? good_run_reg :
                         !l1_err_ok ? 3'h0 :
                         (good_run_reg == 3'h7) ? good_run_reg : good_run_reg + 3'h1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) good_run_reg <= 3'h0;
    else good_run_reg <= good_run_next;
  end

  // more cycles than the qualify count
  assign first_loop_lock_live = l1_enable && (good_run_reg > {1'b0, good_count_reg});

  // Second loop lock
  logic second_loop_lock_live;
  logic l2_mode_ok;
  // only where the second loop is used
  assign l2_mode_ok = (cfg_reg.mode == MODE_DUAL) || (cfg_reg.mode == MODE_SYNTH);
  // calibration done and voltage in window, input not static
  assign second_loop_lock_live = l2_mode_ok && wd_alive[2] &&
                                 synth_cal_done && synth_vtune_in_window;

  // Loss events for latched bits
  logic l1_live_d_reg, l2_live_d_reg;
  logic l1_loss, l2_loss;
  assign l1_loss = l1_live_d_reg && !first_loop_lock_live;
  assign l2_loss = l2_live_d_reg && !second_loop_lock_live;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      l1_live_d_reg <= 1'b0;
      l2_live_d_reg <= 1'b0;
    end else begin
      l1_live_d_reg <= first_loop_lock_live;
      l2_live_d_reg <= second_loop_lock_live;
    end
  end

  // Latched bits: write one clears, a same-cycle event wins
  logic clr_l1, clr_l2;
  assign clr_l1 = wr_status && reg_wdata[ST_L1_LATCH_BIT];
  assign clr_l2 = wr_status && reg_wdata[ST_L2_LATCH_BIT];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      first_loop_lock_latched_reg <= 1'b0;
      second_loop_lock_latched_reg <= 1'b0;
    end else begin
      if (l1_loss) first_loop_lock_latched_reg <= 1'b1;
      else if (clr_l1) first_loop_lock_latched_reg <= 1'b0;
      if (l2_loss) second_loop_lock_latched_reg <= 1'b1;
      else if (clr_l2) second_loop_lock_latched_reg <= 1'b0;
    end
  end

  pfl_status_s status;
  assign status.l1_live = first_loop_lock_live;
  assign status.l2_live = second_loop_lock_live;
  assign status.l1_latched = first_loop_lock_latched_reg;
  assign status.l2_latched = second_loop_lock_latched_reg;

  // General pins, two select bits per pin
  logic [1:0] gpio_reg;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_gpio
      logic [1:0] sel;
      logic pin_val;
      assign sel = gpio_sel_reg[2*gi +: 2];
      // lock and loss interrupt on pins
      assign pin_val = (sel == GPIO_SRC_L1_LOCK) ? first_loop_lock_live :
                       (sel == GPIO_SRC_L2_LOCK) ? second_loop_lock_live :
                       (sel == GPIO_SRC_L1_LOSS) ? first_loop_lock_latched_reg : 1'b0;
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) gpio_reg[gi] <= 1'b0;
        else gpio_reg[gi] <= pin_val;
      end
    end
  endgenerate
  assign gpio_out = gpio_reg;

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  assign rd_mux = (reg_addr == ADDR_LOOP_CFG) ? {1'b0, cfg_reg} :
                  (reg_addr == ADDR_TH_LO) ? phase_window_threshold_reg[7:0] :
                  (reg_addr == ADDR_TH_HI) ? {1'b0, phase_window_threshold_reg[14:8]} :
                  (reg_addr == ADDR_GOOD_CNT) ? {6'h00, good_count_reg} :
                  (reg_addr == ADDR_M0_LO) ? first_loop_feedback_div_reg[7:0] :
                  (reg_addr == ADDR_M0_HI) ? {1'b0, first_loop_feedback_div_reg[14:8]} :
                  (reg_addr == ADDR_M1_LO) ? cascade_feedback_div_reg[7:0] :
                  (reg_addr == ADDR_M1_HI) ? {2'h0, cascade_feedback_div_reg[13:8]} :
                  (reg_addr == ADDR_P1) ? {1'b0, synth_ref_prediv_reg} :
                  (reg_addr == ADDR_GPIO_SEL) ? {4'h0, gpio_sel_reg} :
                  (reg_addr == ADDR_SYNTH_DIV_HI) ? synth_feedback_divider_hi_reg :
                  (reg_addr == ADDR_SYNTH_DIV_LO) ? synth_feedback_divider_lo_reg :
                  (reg_addr == ADDR_STATUS) ? {4'h0, status} : 8'h00;

  // Read data held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) reg_rdata_reg <= 8'h00;
    else if (reg_rd_en) reg_rdata_reg <= rd_mux;
  end
  assign reg_rdata = reg_rdata_reg;

endmodule : pfl_lock_ctrl

// ### pfl_lock_ctrl_monitor.sv
/*
  Checker for pfl_lock_ctrl: lock pins, config flags and register reads.
  Assumes only the top ports are visible; it is bound in below.
*/
`timescale 1ns/100ps
module pfl_lock_ctrl_monitor
  import pfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ref_pd_tick,
  input wire logic holdover,
  input wire logic synth_cal_done,
  input wire logic synth_vtune_in_window,
  input wire logic synth_doubler_on,
  input wire logic oscillator_center_force,
  input wire logic [1:0] gpio_out
);
  logic [3:0] sel_q;
  pfl_mode_e mode_q;
  logic [7:0] div_hi_q;
  logic [9:0] idle_q;

  // Shadow of written fields, so pin checks know what each pin shows
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= GPIO_SEL_RST;
      mode_q <= MODE_DUAL;
      div_hi_q <= SYNTH_DIV_HI_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == ADDR_GPIO_SEL) sel_q <= reg_wdata[3:0];
      if (reg_addr == ADDR_LOOP_CFG) mode_q <= pfl_mode_e'(reg_wdata[6:5]);
      if (reg_addr == ADDR_SYNTH_DIV_HI) div_hi_q <= reg_wdata;
    end
  end

  // Saturating gap count on the reference tick
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) idle_q <= '0;
    else if (ref_pd_tick) idle_q <= '0;
    else if (idle_q != 10'h3FF) idle_q <= idle_q + 10'h001;
  end

  // Qualifiers; a few cycles of slack cover the registered pin path
  wire clr1 = reg_wr_en && reg_addr == ADDR_STATUS && reg_wdata[ST_L1_LATCH_BIT];
  wire pin0_l1 = sel_q[1:0] == GPIO_SRC_L1_LOCK;
  wire pin1_l2 = sel_q[3:2] == GPIO_SRC_L2_LOCK;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  AST_FORCE_UNLOCK: assert property ((pin0_l1 && oscillator_center_force)[*4] |-> !gpio_out[0])
    else $error("pin0 shows lock while centering is forced");
  AST_HOLD_UNLOCK: assert property ((pin0_l1 && holdover)[*4] |-> !gpio_out[0])
    else $error("pin0 shows lock during holdover");
  AST_BYPASS_NO_L1: assert property ((pin0_l1 && mode_q == MODE_BYPASS)[*4] |-> !gpio_out[0])
    else $error("pin0 shows lock in bypass mode");
  AST_STATIC_L1: assert property (pin0_l1 && idle_q > STATIC_CYCLES + 4 |-> !gpio_out[0])
    else $error("pin0 shows lock with a static reference");
  AST_L2_NEEDS_CAL: assert property ((pin1_l2 && !(synth_cal_done && synth_vtune_in_window))[*4] |->
    !gpio_out[1])
    else $error("pin1 shows lock without calibration and window");
  AST_L2_MODE: assert property ((pin1_l2 && mode_q inside {MODE_VCXO, MODE_BYPASS})[*4] |-> !gpio_out[1])
    else $error("pin1 shows lock with second loop unused");
  AST_DIV_HI_READ: assert property (reg_rd_en && !reg_wr_en && reg_addr == ADDR_SYNTH_DIV_HI |=>
    reg_rdata == div_hi_q)
    else $error("divider high byte read back wrong");
  AST_DOUBLER_FLAG: assert property (reg_wr_en && reg_addr == ADDR_LOOP_CFG |=>
    synth_doubler_on == $past(reg_wdata[CFG_DOUBLER_BIT]))
    else $error("doubler flag does not follow config write");
  AST_FORCE_FLAG: assert property (reg_wr_en && reg_addr == ADDR_LOOP_CFG |=>
    oscillator_center_force == $past(reg_wdata[CFG_FORCE_BIT]))
    else $error("centering force does not follow config write");
  AST_LOSS_HOLD: assert property (sel_q[1:0] == GPIO_SRC_L1_LOSS && $past(sel_q[1:0]) == GPIO_SRC_L1_LOSS &&
    gpio_out[0] && !clr1 && !$past(clr1) |=> gpio_out[0])
    else $error("latched loss dropped without a clear");
endmodule : pfl_lock_ctrl_monitor

bind pfl_lock_ctrl pfl_lock_ctrl_monitor u_mon (.core_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata, .ref_pd_tick, .holdover, .synth_cal_done, .synth_vtune_in_window, .synth_doubler_on,
  .oscillator_center_force, .gpio_out);

// ### pfl_lock_ctrl_tb_top.sv
/*
  Testbench for pfl_lock_ctrl: divider routing, lock flags and pins.
  Assumes the monitor file is compiled with it; ticks run every cycle.
*/
`timescale 1ns/100ps
module pfl_lock_ctrl_tb_top
  import pfl_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic ref_in_tick = 1'b1;
  logic ref_pd_tick = 1'b1;
  logic vcxo_tick = 1'b1;
  logic vco_tick = 1'b1;
  logic [14:0] pd_phase_err = 15'h0000;
  logic holdover = 1'b0;
  logic synth_cal_done = 1'b0;
  logic synth_vtune_in_window = 1'b0;
  logic [7:0] reg_rdata;
  logic first_loop_fb_tick, synth_fb_tick, synth_pfd_tick, synth_doubler_on;
  logic vco_eff_tick, delay_ref_tick, oscillator_center_force;
  logic [1:0] gpio_out;
  logic [7:0] d;
  int failures = 0;
  int n_checks = 0;
  wire [4:0] outs = {delay_ref_tick, synth_fb_tick, vco_eff_tick, synth_pfd_tick, first_loop_fb_tick};

  pfl_lock_ctrl dut (.core_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
    .ref_in_tick, .ref_pd_tick, .vcxo_tick, .vco_tick, .pd_phase_err, .holdover, .synth_cal_done,
    .synth_vtune_in_window, .first_loop_fb_tick, .synth_fb_tick, .synth_pfd_tick, .synth_doubler_on,
    .vco_eff_tick, .delay_ref_tick, .oscillator_center_force, .gpio_out);

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_b(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: level %b, expected %b", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR %0t: tick period %0d, expected %0d", $time, got, exp);
    end
  endtask : chk_n

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // Strobe drops with a spare edge so back-to-back calls never overlap
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
  endtask : rd

  // Third gap is measured, so leftover divider state has flushed
  task automatic period(input int i, input int exp);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (outs[i] !== 1'b1 && n < 100);
    end
    chk_n(n, exp);
  endtask : period

  task automatic wait_pin(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (gpio_out[b] !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    chk_b(gpio_out[b], v);
  endtask : wait_pin

  task automatic t_reset();
    logic [7:0] a [12];
    logic [7:0] e [12];
    a = '{ADDR_LOOP_CFG, ADDR_GPIO_SEL, ADDR_SYNTH_DIV_HI, ADDR_SYNTH_DIV_LO, 8'h2A, ADDR_TH_LO, ADDR_TH_HI,
      ADDR_GOOD_CNT, ADDR_M0_LO, ADDR_M1_LO, ADDR_P1, ADDR_STATUS};
    e = '{LOOP_CFG_RST, {4'h0, GPIO_SEL_RST}, SYNTH_DIV_HI_RST, SYNTH_DIV_LO_RST, 8'h00, TH_RST[7:0],
      {1'b0, TH_RST[14:8]}, {6'h00, GOOD_CNT_RST}, M0_RST[7:0], M1_RST[7:0], {1'b0, P1_RST}, 8'h00};
    chk_b(oscillator_center_force, 1'b1);
    for (int i = 0; i < 12; i++) begin
      rd(a[i], d);
      chk8(d, e[i]);
    end
    wr(ADDR_SYNTH_DIV_HI, 8'hA5);
    rd(ADDR_SYNTH_DIV_HI, d);
    chk8(d, 8'hA5);
    wr(ADDR_SYNTH_DIV_HI, 8'h00);
  endtask : t_reset

  task automatic t_divs();
    logic [7:0] c [10];
    int k [10];
    int x [10];
    c = '{8'h10, 8'h12, 8'h11, 8'h10, 8'h18, 8'h10, 8'h14, 8'h10, 8'h14, 8'h14};
    k = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 4};
    x = '{5, 10, 15, 3, 1, 1, 2, 6, 12, 2};
    wr(ADDR_M0_LO, 8'h05);
    wr(ADDR_M1_LO, 8'h03);
    wr(ADDR_P1, 8'h03);
    wr(ADDR_SYNTH_DIV_LO, 8'h06);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_LOOP_CFG, c[i]);
      chk_b(synth_doubler_on, c[i][CFG_DOUBLER_BIT]);
      period(k[i], x[i]);
    end
  endtask : t_divs

  task automatic t_lock1();
    // Qualify count 3 needs four good feedback ticks; error one above threshold
    wr(ADDR_GOOD_CNT, 8'h03);
    wr(ADDR_TH_LO, 8'h20);
    pd_phase_err <= 15'h0021;
    wr(ADDR_LOOP_CFG, 8'h00);
    idle(60);
    chk_b(gpio_out[0], 1'b0);
    pd_phase_err <= 15'h0020;
    idle(12);
    chk_b(gpio_out[0], 1'b0);
    wait_pin(0, 1'b1, 60);
    rd(ADDR_STATUS, d);
    chk8(d, 8'h01);
    wr(ADDR_LOOP_CFG, 8'h10);
    wait_pin(0, 1'b0, 10);
    rd(ADDR_STATUS, d);
    chk8(d, 8'h04);
    wr(ADDR_GPIO_SEL, 8'h06);
    wait_pin(0, 1'b1, 4);
    wr(ADDR_STATUS, 8'h04);
    wait_pin(0, 1'b0, 4);
    wr(ADDR_GPIO_SEL, {4'h0, GPIO_SEL_RST});
    wr(ADDR_LOOP_CFG, 8'h00);
    wait_pin(0, 1'b1, 60);
    holdover <= 1'b1;
    wait_pin(0, 1'b0, 10);
    holdover <= 1'b0;
    wait_pin(0, 1'b1, 60);
    wr(ADDR_LOOP_CFG, 8'h60);
    wait_pin(0, 1'b0, 10);
    wr(ADDR_LOOP_CFG, 8'h40);
    wait_pin(0, 1'b1, 60);
    vcxo_tick <= 1'b0;
    ref_pd_tick <= 1'b0;
    idle(400);
    chk_b(gpio_out[0], 1'b1);
    wait_pin(0, 1'b0, 200);
    vcxo_tick <= 1'b1;
    ref_pd_tick <= 1'b1;
  endtask : t_lock1

  task automatic t_lock2();
    wr(ADDR_LOOP_CFG, 8'h10);
    wr(ADDR_STATUS, 8'h0C);
    synth_cal_done <= 1'b1;
    idle(20);
    chk_b(gpio_out[1], 1'b0);
    synth_vtune_in_window <= 1'b1;
    wait_pin(1, 1'b1, 20);
    wr(ADDR_GPIO_SEL, 8'h0C);
    wait_pin(1, 1'b0, 4);
    wr(ADDR_GPIO_SEL, {4'h0, GPIO_SEL_RST});
    wait_pin(1, 1'b1, 4);
    rd(ADDR_STATUS, d);
    chk8(d, 8'h02);
    synth_vtune_in_window <= 1'b0;
    wait_pin(1, 1'b0, 10);
    rd(ADDR_STATUS, d);
    chk8(d, 8'h08);
    synth_vtune_in_window <= 1'b1;
    wait_pin(1, 1'b1, 20);
    wr(ADDR_LOOP_CFG, 8'h50);
    wait_pin(1, 1'b0, 10);
    wr(ADDR_LOOP_CFG, 8'h30);
    wait_pin(1, 1'b1, 20);
    ref_in_tick <= 1'b0;
    wait_pin(1, 1'b0, 600);
    ref_in_tick <= 1'b1;
  endtask : t_lock2

  // Main sequence; reset held for eight edges
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_divs();
    t_lock1();
    t_lock2();
    stop_test();
  end

  // Run needs under two thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    stop_test();
  end
endmodule : pfl_lock_ctrl_tb_top
